// file: hdl/fpt_pkg.sv
/*
  constants, address map and carrier types for the front panel timing block.
  assumes a 125 MHz system clock and a regenerated 3.6864 MHz master clock pin.
*/
package fpt_pkg;
  // ----------------------------------------------------------------
  // clock rates and derived counts
  // ----------------------------------------------------------------
  localparam longint CLK_HZ          = 125000000;
  localparam longint MCLK_HZ         = 3686400;       // regenerated master clock
  localparam int     TB_WIDTH        = 12;            // master clock counter chain
  localparam int     DIV8_BIT        = 2;             // bit toggling at master / 8
  localparam int     DIV900_BIT      = 11;            // bit toggling at master / 4096
  // filament phases, in master clock periods (rounded to nearest)
  localparam longint FIL_HIGH_NS     = 6510;
  localparam longint FIL_DEAD_NS     = 2170;
  localparam longint FIL_HIGH_TICKS  = (FIL_HIGH_NS * MCLK_HZ + 500000000) / 1000000000;
  localparam longint FIL_DEAD_TICKS  = (FIL_DEAD_NS * MCLK_HZ + 500000000) / 1000000000;
  localparam logic [5:0] FIL_HIGH_LAST = 6'(FIL_HIGH_TICKS - 1);
  localparam logic [5:0] FIL_DEAD_LAST = 6'(FIL_DEAD_TICKS - 1);
  // refresh watchdog timeout
  localparam longint WDOG_TIMEOUT_MS = 40;
  localparam longint WDOG_CYCLES     = WDOG_TIMEOUT_MS * CLK_HZ / 1000;
  // ----------------------------------------------------------------
  // control display refresh geometry, in 460.8 kHz ticks
  // ----------------------------------------------------------------
  localparam int         CD_GRIDS      = 129;
  localparam logic [6:0] CD_LAST_GRID  = 7'h7f;        // grid 128, last one driven
  localparam logic [4:0] CD_ANODES     = 5'h1a;        // anodes per column
  localparam logic [5:0] GRID_STEP_LAST = 6'h2f;       // 48 ticks per grid step
  // ----------------------------------------------------------------
  // panel address map
  // ----------------------------------------------------------------
  localparam logic [23:0] OTD_FIRST  = 24'hd02000;
  localparam logic [23:0] OTD_LAST   = 24'hd027ff;
  localparam logic [23:0] CTD_FIRST  = 24'hd02800;
  localparam logic [23:0] CTD_LAST   = 24'hd02fff;
  localparam logic [23:0] KNOB_FIRST = 24'hd03000;
  localparam logic [23:0] KNOB_LAST  = 24'hd033ff;
  localparam logic [23:0] LAMP_FIRST = 24'hd03400;
  localparam logic [23:0] LAMP_LAST  = 24'hd037ff;
  localparam logic [23:0] KEY_FIRST  = 24'hd03800;
  localparam logic [23:0] KEY_LAST   = 24'hd03bff;
  // status byte bit positions
  localparam int ST_FAIL = 0;
  localparam int ST_HOLD = 1;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [23:0] addr;
  } fpt_req_t;
  // active-high select set, one bit per panel resource
  typedef struct packed {
    logic otd;
    logic ctd;
    logic knob_rd;
    logic knob_clr;
    logic lamp_rd;
    logic lamp_wr;
    logic key;
  } fpt_sel_t;
endpackage : fpt_pkg

// file: hdl/fpt_timebase.sv
/*
  master clock regeneration counter: synchronises the master clock pin,
  turns each rising edge into a one-cycle tick and runs the divider chain.
  assumes the pin runs well below half of REF_CLK.
*/
module fpt_timebase
  import fpt_pkg::*;
(
  input  wire logic                clk,       // system clock
  input  wire logic                rst_n,     // async reset, low
  input  wire logic                mclk_pin,  // master clock pin
  output logic                     mtick,     // one pulse per master rising edge
  output logic [TB_WIDTH-1:0]      chain      // divider chain value
);
  logic       sync1_reg;
  logic       sync2_reg;
  logic       prev_reg;
  logic [TB_WIDTH-1:0] chain_next;

  // ----------------------------------------------------------------
  // pin synchroniser and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
      mtick     <= 1'b0;
    end else begin
      sync1_reg <= mclk_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      mtick     <= sync2_reg & ~prev_reg;
    end
  end

  // ----------------------------------------------------------------
  // divider chain
  // ----------------------------------------------------------------
  assign chain_next = chain + TB_WIDTH'(1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chain <= '0;
    end else if (mtick) begin
      chain <= chain_next;
    end
  end
endmodule : fpt_timebase

// file: hdl/fpt_panel.sv
/*
  front panel timing, refresh guard and address decode.
  assumes synchronous host strobes on REF_CLK and asynchronous panel pins.
*/
// The placing of the registers and strobed register access were left to the implementer.
// What this block does
// - divide master clock by eight, inverted, giving the 460.8 kHz clock.
// - same chain divides further to a 900 Hz timing output.
// - each refresh pulse from the last grid driver clears the watchdog.
// - watchdog expiry sets a failure latch that stays set.
// - failure latch drives the high-voltage supply shutdown.
// - failure raises low supply-fail interrupt and blanks both displays.
// - refresh and filament state machines; filament gives two 57.6 kHz phases.
// - produce grid master strobe and general master strobe.
// - drive control blank, two anode pair clocks and output display blank.
// - generate bus acknowledge and combined panel interrupt.
// - decode output and control display memory selects.
// - decode knob read/clear, lamp counter/latch and keypad selects.
// - refresh 128 driven grids of 26 anodes; skip column C of last.
// - phases high 6.51 us each with 2.17 us dead time, no overlap.
// - hold acknowledge for control memory writes while contention persists.
module fpt_panel
  import fpt_pkg::*;
#(
  parameter longint WDOG_LIMIT = WDOG_CYCLES  // refresh watchdog, in REF_CLK cycles
)(
  input  wire logic        REF_CLK,                 // 125 MHz clock
  input  wire logic        RSTN,                    // async reset, low
  input  wire logic        MCLK_IN,                 // regenerated master clock pin
  input  wire logic        LAST_GRID_SERIAL_OUT,    // refresh pulse pin
  input  wire logic        CONTROL_MEM_CONTENTION_N,// contention pin, low
  input  wire logic        KNOB_IRQ,                // knob event pin
  input  wire logic        KEYPAD_IRQ,              // keypad event pin
  input  wire logic [23:0] ADDR,                    // host address
  input  wire logic        WR_STB,                  // write strobe
  input  wire logic        RD_STB,                  // read strobe
  output logic      [7:0]  RD_DATA,                 // status byte
  output logic             BUS_ACK,                 // access acknowledge
  output logic             PANEL_IRQ_N,             // panel interrupt, low
  output logic             SUPPLY_FAIL_IRQ_N,       // supply fail interrupt, low
  output logic             HV_SUPPLY_SHUTDOWN,      // supply shutdown
  output logic             TIMING_CLK_460K,         // 460.8 kHz clock
  output logic             TIMING_900HZ,            // 900 Hz timing
  output logic             FILAMENT_PHASE_A,        // filament phase a
  output logic             FILAMENT_PHASE_B,        // filament phase b
  output logic             GRID_MASTER_PULSE,       // grid master strobe
  output logic             GENERAL_MASTER_PULSE,    // general master strobe
  output logic             CONTROL_DISP_BLANK,      // control display blank
  output logic             OUTPUT_DISP_BLANK,       // output display blank
  output logic             ANODE_PAIR1_CLK,         // anode clock, pair one
  output logic             ANODE_PAIR2_CLK,         // anode clock, pair two
  output logic             OUTPUT_DISP_MEM_SEL_N,   // output memory select, low
  output logic             CONTROL_DISP_MEM_SEL_N,  // control memory select, low
  output logic             KNOB_READ_SEL_N,         // knob read select, low
  output logic             KNOB_CLEAR_N,            // knob clear strobe, low
  output logic             LAMP_COUNTER_READ,       // lamp counter read
  output logic             LAMP_LATCH_WRITE,        // lamp latch write
  output logic             KEYPAD_SEL_N             // keypad select, low
);
  typedef enum logic [1:0] {FL_A, FL_DEAD1, FL_B, FL_DEAD2} fpt_fil_t;
  typedef enum logic [1:0] {RF_BLANK, RF_LOAD, RF_SHOW} fpt_ref_t;

  logic [TB_WIDTH-1:0] chain;
  logic       mtick;
  logic       tick460;
  logic       chain2_prev_reg;
  logic [4:0] pin1_reg;
  logic [4:0] pin2_reg;
  logic       refr_prev_reg;
  logic       refr_edge;
  logic [31:0] wdog_reg;
  logic       fail_reg;
  fpt_fil_t   fil_state_reg;
  logic [5:0] fil_cnt_reg;
  fpt_ref_t   ref_state_reg;
  logic [5:0] step_cnt_reg;
  logic [6:0] grid_reg;
  logic       load_pair2;
  fpt_req_t   req;
  fpt_sel_t   sel_next;
  fpt_sel_t   sel_reg;
  logic       hold_reg;
  logic       cont_low;

  // ----------------------------------------------------------------
  // master clock chain and derived timing
  // ----------------------------------------------------------------
  fpt_timebase u_tb (
    .clk      (REF_CLK),
    .rst_n    (RSTN),
    .mclk_pin (MCLK_IN),
    .mtick    (mtick),
    .chain    (chain)
  );

  // tick on each rising edge of the /8 stage
  assign tick460 = chain[DIV8_BIT] & ~chain2_prev_reg;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      chain2_prev_reg <= 1'b0;
      TIMING_CLK_460K <= 1'b1;
      TIMING_900HZ    <= 1'b0;
    end else begin
      chain2_prev_reg <= chain[DIV8_BIT];
      TIMING_CLK_460K <= ~chain[DIV8_BIT];
      TIMING_900HZ    <= chain[DIV900_BIT];
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers: refresh, contention, knob, keypad, spare
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin1_reg      <= 5'h02;
      pin2_reg      <= 5'h02;
      refr_prev_reg <= 1'b0;
    end else begin
      pin1_reg      <= {1'b0, KEYPAD_IRQ, KNOB_IRQ, CONTROL_MEM_CONTENTION_N,
                        LAST_GRID_SERIAL_OUT};
      pin2_reg      <= pin1_reg;
      refr_prev_reg <= pin2_reg[0];
    end
  end

  assign refr_edge = pin2_reg[0] & ~refr_prev_reg;
  assign cont_low  = ~pin2_reg[1];

  // ----------------------------------------------------------------
  // refresh watchdog and failure latch
  // ----------------------------------------------------------------
  // cleared by refresh
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wdog_reg <= '0;
    end else if (refr_edge) begin
      wdog_reg <= '0;
    end else if (wdog_reg != 32'(WDOG_LIMIT - 1)) begin
      wdog_reg <= wdog_reg + 32'h1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fail_reg <= 1'b0;
    end else if (wdog_reg == 32'(WDOG_LIMIT - 1)) begin
      fail_reg <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      HV_SUPPLY_SHUTDOWN <= 1'b0;
      SUPPLY_FAIL_IRQ_N  <= 1'b1;
      OUTPUT_DISP_BLANK  <= 1'b1;
    end else begin
      HV_SUPPLY_SHUTDOWN <= fail_reg;
      SUPPLY_FAIL_IRQ_N  <= ~fail_reg;
      OUTPUT_DISP_BLANK  <= fail_reg | (ref_state_reg == RF_BLANK);
    end
  end

  // ----------------------------------------------------------------
  // filament sequencer
  // ----------------------------------------------------------------
  // alternating phases with dead time
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fil_state_reg <= FL_DEAD2;
      fil_cnt_reg   <= '0;
    end else if (mtick) begin
      fil_cnt_reg <= fil_cnt_reg + 6'h1;
      case (fil_state_reg)
        FL_A: begin
          if (fil_cnt_reg == FIL_HIGH_LAST) begin
            fil_state_reg <= FL_DEAD1;
            fil_cnt_reg   <= '0;
          end
        end
        FL_DEAD1: begin
          if (fil_cnt_reg == FIL_DEAD_LAST) begin
            fil_state_reg <= FL_B;
            fil_cnt_reg   <= '0;
          end
        end
        FL_B: begin
          if (fil_cnt_reg == FIL_HIGH_LAST) begin
            fil_state_reg <= FL_DEAD2;
            fil_cnt_reg   <= '0;
          end
        end
        default: begin
          if (fil_cnt_reg == FIL_DEAD_LAST) begin
            fil_state_reg <= FL_A;
            fil_cnt_reg   <= '0;
          end
        end
      endcase
    end
  end

  // phase outputs
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      FILAMENT_PHASE_A <= 1'b0;
      FILAMENT_PHASE_B <= 1'b0;
    end else begin
      FILAMENT_PHASE_A <= (fil_state_reg == FL_A);
      FILAMENT_PHASE_B <= (fil_state_reg == FL_B);
    end
  end

  // ----------------------------------------------------------------
  // control display refresh sequencer
  // ----------------------------------------------------------------
  // blank, load 26 anodes, show; 128 grids
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ref_state_reg <= RF_BLANK;
      step_cnt_reg  <= '0;
      grid_reg      <= '0;
    end else if (tick460) begin
      step_cnt_reg <= step_cnt_reg + 6'h1;
      case (ref_state_reg)
        RF_BLANK: begin
          ref_state_reg <= RF_LOAD;
        end
        RF_LOAD: begin
          if (step_cnt_reg == 6'(CD_ANODES)) begin
            ref_state_reg <= RF_SHOW;
          end
        end
        default: begin
          if (step_cnt_reg == GRID_STEP_LAST) begin
            ref_state_reg <= RF_BLANK;
            step_cnt_reg  <= '0;
            grid_reg      <= grid_reg + 7'h1;
          end
        end
      endcase
    end
  end

  // odd steps load the C/D pair; column C of the last grid is unused
  assign load_pair2 = grid_reg[0] & (grid_reg != CD_LAST_GRID);

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      GRID_MASTER_PULSE    <= 1'b0;
      GENERAL_MASTER_PULSE <= 1'b0;
      CONTROL_DISP_BLANK   <= 1'b1;
      ANODE_PAIR1_CLK      <= 1'b0;
      ANODE_PAIR2_CLK      <= 1'b0;
    end else begin
      GRID_MASTER_PULSE    <= tick460 & (ref_state_reg == RF_BLANK);
      GENERAL_MASTER_PULSE <= tick460;
      CONTROL_DISP_BLANK   <= fail_reg | (ref_state_reg == RF_BLANK);
      ANODE_PAIR1_CLK      <= (ref_state_reg == RF_LOAD) & ~grid_reg[0] & chain[DIV8_BIT];
      ANODE_PAIR2_CLK      <= (ref_state_reg == RF_LOAD) & load_pair2 & chain[DIV8_BIT];
    end
  end

  // ----------------------------------------------------------------
  // host address decode
  // ----------------------------------------------------------------
  assign req = '{wr: WR_STB, rd: RD_STB, addr: ADDR};

  always_comb begin
    sel_next = '0;
    if (!(req.wr | req.rd)) begin
      sel_next = '0;
    end else if (req.addr >= OTD_FIRST && req.addr <= OTD_LAST) begin
      sel_next.otd = 1'b1;
    end else if (req.addr >= CTD_FIRST && req.addr <= CTD_LAST) begin
      sel_next.ctd = 1'b1;
    end else if (req.addr >= KNOB_FIRST && req.addr <= KNOB_LAST) begin
      sel_next.knob_rd  = req.rd;
      sel_next.knob_clr = req.wr;
    end else if (req.addr >= LAMP_FIRST && req.addr <= LAMP_LAST) begin
      sel_next.lamp_rd = req.rd;
      sel_next.lamp_wr = req.wr;
    end else if (req.addr >= KEY_FIRST && req.addr <= KEY_LAST) begin
      sel_next.key = 1'b1;
    end
  end

  // selects and acknowledge, held on contention
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sel_reg  <= '0;
      hold_reg <= 1'b0;
      BUS_ACK  <= 1'b0;
    end else if (hold_reg) begin
      // select stands through the acknowledge cycle, drops after
      hold_reg <= cont_low;
      BUS_ACK  <= ~cont_low;
    end else begin
      sel_reg  <= sel_next;
      hold_reg <= sel_next.ctd & req.wr & cont_low;
      BUS_ACK  <= (sel_next != '0) & ~(sel_next.ctd & req.wr & cont_low);
    end
  end

  assign OUTPUT_DISP_MEM_SEL_N  = ~sel_reg.otd;
  assign CONTROL_DISP_MEM_SEL_N = ~sel_reg.ctd;
  assign KNOB_READ_SEL_N        = ~sel_reg.knob_rd;
  assign KNOB_CLEAR_N           = ~sel_reg.knob_clr;
  assign LAMP_COUNTER_READ      = sel_reg.lamp_rd;
  assign LAMP_LATCH_WRITE       = sel_reg.lamp_wr;
  assign KEYPAD_SEL_N           = ~sel_reg.key;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PANEL_IRQ_N <= 1'b1;
      RD_DATA     <= 8'h00;
    end else begin
      PANEL_IRQ_N <= ~(pin2_reg[2] | pin2_reg[3]);
      RD_DATA     <= 8'h00;
      if (req.rd) begin
        RD_DATA[ST_FAIL] <= fail_reg;
        RD_DATA[ST_HOLD] <= hold_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_fail_set;
    !fail_reg ##1 fail_reg;
  endsequence
  sequence s_shut_and_irq;
    HV_SUPPLY_SHUTDOWN && !SUPPLY_FAIL_IRQ_N;
  endsequence

  wdog_clear_a: assert property (refr_edge |=> wdog_reg == 32'h0)
    else $error("watchdog not cleared by refresh");
  fail_sticky_a: assert property (fail_reg |=> fail_reg)
    else $error("failure latch dropped");
  shutdown_follow_a: assert property (s_fail_set |=> s_shut_and_irq)
    else $error("shutdown or fail interrupt late");
  fail_blank_a: assert property (!SUPPLY_FAIL_IRQ_N |-> CONTROL_DISP_BLANK && OUTPUT_DISP_BLANK)
    else $error("display not blanked on failure");
  phase_overlap_a: assert property (!(FILAMENT_PHASE_A && FILAMENT_PHASE_B))
    else $error("filament phases overlap");
  phase_dead_a: assert property ($fell(FILAMENT_PHASE_A) |-> !FILAMENT_PHASE_B [*8])
    else $error("no dead time after phase a");
  otd_decode_a: assert property (WR_STB && ADDR >= OTD_FIRST && ADDR <= OTD_LAST
                                 |=> !OUTPUT_DISP_MEM_SEL_N)
    else $error("output memory select missing");
  sel_onehot_a: assert property ($onehot0(sel_reg))
    else $error("more than one select");
  ack_hold_a: assert property (hold_reg && cont_low |=> !BUS_ACK && !CONTROL_DISP_MEM_SEL_N)
    else $error("acknowledge given under contention");
endmodule : fpt_panel

// file: test/fpt_far_model.sv
/*
  far side model: master clock, refresh pulses from the last grid driver,
  control memory contention. assumes the bench clock on clk.
*/
module fpt_far_model (
  input  wire logic clk,        // bench clock
  input  wire logic fast,       // short master period
  input  wire logic refresh_en, // send refresh pulses
  input  wire logic busy,       // hold contention
  output logic      mclk,       // master clock
  output logic      grid_out,   // refresh pulse
  output logic      busy_n      // contention, low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial mclk = 1'b0;
  initial grid_out = 1'b0;
  // master clock, 136 ns or 24 ns half period
  always #(fast ? 24 : 136) mclk = ~mclk;
  // refresh pulse every 104 cycles, 4 cycles wide
  always begin
    repeat (100) @(posedge clk);
    grid_out <= refresh_en;
    repeat (4) @(posedge clk);
    grid_out <= 1'b0;
  end
  // contention only while the bench asks
  assign busy_n = ~busy;
endmodule : fpt_far_model

// file: test/testbench.sv
/*
  self-checking bench for the front panel timing block.
  assumes fpt_pkg, fpt_panel and the far side model are compiled first.
*/
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
`define GAP(a, b, p) begin @(a); t0 = $realtime; @(b); p = int'($realtime - t0); end
module testbench
  import fpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK = 1'b0, RSTN = 1'b0, WR_STB = 1'b0, RD_STB = 1'b0;
  logic        KNOB_IRQ = 1'b0, KEYPAD_IRQ = 1'b0;
  logic        fast = 1'b1, refresh_en = 1'b1, busy = 1'b0;
  logic [23:0] ADDR = 24'h000000;
  logic [7:0]  RD_DATA;
  logic        MCLK_IN, LAST_GRID_SERIAL_OUT, CONTROL_MEM_CONTENTION_N, BUS_ACK, PANEL_IRQ_N;
  logic        SUPPLY_FAIL_IRQ_N, HV_SUPPLY_SHUTDOWN, TIMING_CLK_460K, TIMING_900HZ;
  logic        FILAMENT_PHASE_A, FILAMENT_PHASE_B, GRID_MASTER_PULSE, GENERAL_MASTER_PULSE;
  logic        CONTROL_DISP_BLANK, OUTPUT_DISP_BLANK, ANODE_PAIR1_CLK, ANODE_PAIR2_CLK;
  logic        OUTPUT_DISP_MEM_SEL_N, CONTROL_DISP_MEM_SEL_N, KNOB_READ_SEL_N, KNOB_CLEAR_N;
  logic        LAMP_COUNTER_READ, LAMP_LATCH_WRITE, KEYPAD_SEL_N;
  fpt_sel_t    exp_q [$];
  fpt_sel_t    obs, e_sel;
  int          num_errors = 0, checks = 0, cycles = 0;
  logic [1:0]  anode_seen = 2'b00;
  realtime     t0;
  logic [23:0] bounds [10] = '{24'hd01fff, 24'hd027ff, 24'hd02800, 24'hd02fff, 24'hd03000,
                               24'hd033ff, 24'hd03400, 24'hd037ff, 24'hd03bff, 24'hd03c00};

  fpt_panel #(.WDOG_LIMIT(200)) i_fpt_panel (
    .REF_CLK, .RSTN, .MCLK_IN, .LAST_GRID_SERIAL_OUT, .CONTROL_MEM_CONTENTION_N, .KNOB_IRQ,
    .KEYPAD_IRQ, .ADDR, .WR_STB, .RD_STB, .RD_DATA, .BUS_ACK, .PANEL_IRQ_N,
    .SUPPLY_FAIL_IRQ_N, .HV_SUPPLY_SHUTDOWN, .TIMING_CLK_460K, .TIMING_900HZ,
    .FILAMENT_PHASE_A, .FILAMENT_PHASE_B, .GRID_MASTER_PULSE, .GENERAL_MASTER_PULSE,
    .CONTROL_DISP_BLANK, .OUTPUT_DISP_BLANK, .ANODE_PAIR1_CLK, .ANODE_PAIR2_CLK,
    .OUTPUT_DISP_MEM_SEL_N, .CONTROL_DISP_MEM_SEL_N, .KNOB_READ_SEL_N, .KNOB_CLEAR_N,
    .LAMP_COUNTER_READ, .LAMP_LATCH_WRITE, .KEYPAD_SEL_N
  );
  fpt_far_model i_fpt_far_model (
    .clk(REF_CLK), .fast, .refresh_en, .busy, .mclk(MCLK_IN),
    .grid_out(LAST_GRID_SERIAL_OUT), .busy_n(CONTROL_MEM_CONTENTION_N)
  );

  always #4 REF_CLK = ~REF_CLK;
  assign obs = {~OUTPUT_DISP_MEM_SEL_N, ~CONTROL_DISP_MEM_SEL_N, ~KNOB_READ_SEL_N,
                ~KNOB_CLEAR_N, LAMP_COUNTER_READ, LAMP_LATCH_WRITE, ~KEYPAD_SEL_N};

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // expected select set for one access
  function automatic fpt_sel_t exp_sel(input logic w, input logic [23:0] a);
    fpt_sel_t s;
    s.otd      = (a >= OTD_FIRST) && (a <= OTD_LAST);
    s.ctd      = (a >= CTD_FIRST) && (a <= CTD_LAST);
    s.knob_rd  = !w && (a >= KNOB_FIRST) && (a <= KNOB_LAST);
    s.knob_clr = w && (a >= KNOB_FIRST) && (a <= KNOB_LAST);
    s.lamp_rd  = !w && (a >= LAMP_FIRST) && (a <= LAMP_LAST);
    s.lamp_wr  = w && (a >= LAMP_FIRST) && (a <= LAMP_LAST);
    s.key      = (a >= KEY_FIRST) && (a <= KEY_LAST);
    return s;
  endfunction : exp_sel
  // snap a measured time to the expected one within 8 ns
  function automatic int near(input int p, input int e);
    return ((p > e - 9) && (p < e + 9)) ? e : p;
  endfunction : near
  // one bus cycle, strobe left up for a following access
  task automatic acc(input logic w, input logic [23:0] a);
    fpt_sel_t s;
    s = exp_sel(w, a);
    if (s != '0) exp_q.push_back(s);
    WR_STB <= w;
    RD_STB <= ~w;
    ADDR <= a;
    @(posedge REF_CLK);
  endtask : acc
  // status read at an unmapped place, data checked mid cycle
  task automatic status(input logic [7:0] e);
    acc(1'b0, 24'h000000);
    RD_STB <= 1'b0;
    @(negedge REF_CLK);
    `CHK("status", e, RD_DATA)
    @(posedge REF_CLK);
  endtask : status
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // result watcher and timeout
  // ------------------------------------------------------------
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      wrap_up();
    end
    // outputs are unknown until the first reset edge has landed
    if (cycles > 1) begin
      `CHK("phase_overlap", 1'b0, FILAMENT_PHASE_A & FILAMENT_PHASE_B)
      `CHK("anode_pairs", 1'b0, ANODE_PAIR1_CLK & ANODE_PAIR2_CLK)
      anode_seen = anode_seen | {ANODE_PAIR2_CLK, ANODE_PAIR1_CLK};
    end
    if (BUS_ACK === 1'b1) begin
      `CHK("ack_expected", 1'b1, exp_q.size() > 0)
      if (exp_q.size() > 0) begin
        e_sel = exp_q.pop_front();
        `CHK("selects", e_sel, obs)
      end
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    int p;
    void'($urandom(32'h647a8f57));
    repeat (6) @(posedge REF_CLK);
    `CHK("reset_levels", 8'h73, {HV_SUPPLY_SHUTDOWN, SUPPLY_FAIL_IRQ_N, PANEL_IRQ_N, TIMING_CLK_460K, FILAMENT_PHASE_A, FILAMENT_PHASE_B, CONTROL_DISP_BLANK, OUTPUT_DISP_BLANK})
    RSTN <= 1'b1;
    // master period 48 ns while timing is measured
    `GAP(posedge TIMING_CLK_460K, posedge TIMING_CLK_460K, p)
    `CHK("clk460_period", 384, near(p, 384))
    `GAP(posedge GENERAL_MASTER_PULSE, posedge GENERAL_MASTER_PULSE, p)
    `CHK("strobe_period", 384, near(p, 384))
    `GAP(posedge GRID_MASTER_PULSE, posedge GRID_MASTER_PULSE, p)
    `CHK("grid_strobe_period", 18432, near(p, 18432))
    `GAP(posedge FILAMENT_PHASE_A, negedge FILAMENT_PHASE_A, p)
    `CHK("phase_high", 1152, near(p, 1152))
    `GAP(negedge FILAMENT_PHASE_A, posedge FILAMENT_PHASE_B, p)
    `CHK("phase_dead", 384, near(p, 384))
    `GAP(posedge TIMING_900HZ, posedge TIMING_900HZ, p)
    `CHK("slow_period", 196608, near(p, 196608))
    `CHK("anode_seen", 2'b11, anode_seen)
    $display("test timing done");
    @(posedge REF_CLK);
    fast <= 1'b0;
    for (int i = 0; i < 40; i++) acc(1'($urandom), 24'hd02000 + 24'($urandom % 32'h2000));
    for (int j = 0; j < 20; j++) acc(1'(j), bounds[j / 2]);
    WR_STB <= 1'b0;
    RD_STB <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    `CHK("acks_outstanding", 0, exp_q.size())
    $display("test decode done");
    busy <= 1'b1;
    // let contention pass the two-flop synchroniser first
    repeat (3) @(posedge REF_CLK);
    acc(1'b1, 24'hd02800);
    WR_STB <= 1'b0;
    repeat (10) @(posedge REF_CLK);
    `CHK("held_select", 1'b0, CONTROL_DISP_MEM_SEL_N)
    `CHK("held_ack", 1, exp_q.size())
    busy <= 1'b0;
    repeat (8) @(posedge REF_CLK);
    `CHK("released_ack", 0, exp_q.size())
    $display("test hold done");
    for (int i = 0; i < 4; i++) begin
      {KEYPAD_IRQ, KNOB_IRQ} <= 2'(i);
      repeat (5) @(posedge REF_CLK);
      `CHK("panel_irq_n", i == 0, PANEL_IRQ_N)
    end
    $display("test irq done");
    status(8'h00);
    `CHK("shutdown_idle", 1'b0, HV_SUPPLY_SHUTDOWN)
    refresh_en <= 1'b0;
    repeat (400) @(posedge REF_CLK);
    `CHK("fail_outputs", 4'hb, {HV_SUPPLY_SHUTDOWN, SUPPLY_FAIL_IRQ_N, CONTROL_DISP_BLANK, OUTPUT_DISP_BLANK})
    refresh_en <= 1'b1;
    repeat (500) @(posedge REF_CLK);
    `CHK("fail_latched", 4'hb, {HV_SUPPLY_SHUTDOWN, SUPPLY_FAIL_IRQ_N, CONTROL_DISP_BLANK, OUTPUT_DISP_BLANK})
    status(8'h01);
    RSTN <= 1'b0;
    repeat (6) @(posedge REF_CLK);
    RSTN <= 1'b1;
    repeat (50) @(posedge REF_CLK);
    `CHK("fail_cleared", 2'b01, {HV_SUPPLY_SHUTDOWN, SUPPLY_FAIL_IRQ_N})
    $display("test watchdog done");
    wrap_up();
  end
endmodule : testbench
